// ==== cdg_clock_domains.sv ====
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module cdg_clock_domains
   import cdg_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        osc_clk,
   input  wire logic        pll1_clk,
   input  wire logic        pll2_clk,
   input  wire logic        external_clock_input1,
   input  wire logic        external_clock_input2,
   input  wire logic        low_freq_osc_clock,
   input  wire logic        high_freq_osc_clock,
   input  wire logic        cpu_clock,
   input  wire logic        async_clock1,
   input  wire logic        osc_valid,
   input  wire logic        pll1_valid,
   input  wire logic        pll2_valid,
   input  wire logic        hf_valid,
   input  wire logic [15:0] alt_src_tick,
   output logic             async3_en_q,
   output logic             divided_async3_en_q,
   output logic             async_clock4_en_q,
   output logic             timer_domain_en_q,
   output logic             external_clock_out_pin,
   output logic             timer_output_pin12
);
   // ==========================================================================
   // Registers
   // ==========================================================================
   logic [31:0] ctl1_q;
   logic [31:0] dis_q;
   logic [31:0] tsrc_q;
   logic [31:0] test_q;
   logic [31:0] prdata_d;
   logic        pslverr_d;
   logic        div_tick;
   logic        a3_run;
   logic        tdiv_tick;
   logic [CDG_TDIV_W:0] tdiv_cnt_q;
   logic        tbase_q;
   logic        a3_tog_q;
   logic        a4_tog_q;
   logic [15:0] ecp_src;
   logic [15:0] gio_src;
   logic        wr_en;
   logic        rd_en;

   // Address hit helper, used by read and write decode
   function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
      hit = (a == base);
   endfunction

   function automatic logic mapped(input logic [31:0] a);
      mapped = hit(a, CDG_ADDR_ASYNC_CTL1) | hit(a, CDG_ADDR_DOMAIN_DIS) |
               hit(a, CDG_ADDR_TIMER_SRC) | hit(a, CDG_ADDR_CLOCK_TEST) | hit(a, CDG_ADDR_STATUS);
   endfunction

   // Write qualifier in the access phase, read qualifier in setup; pready is one on every access phase
   assign wr_en = psel & penable & pwrite & pready;
   assign rd_en = psel & ~penable & ~pwrite;

   // ==========================================================================
   // APB write path
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl1_q <= CDG_RST_ASYNC_CTL1;   // Ratio field gives /2
         dis_q  <= CDG_RST_DOMAIN_DIS;
         tsrc_q <= CDG_RST_TIMER_SRC;    // Peripheral clock source
         test_q <= CDG_RST_CLOCK_TEST;
      end else if (wr_en) begin
         if (hit(paddr, CDG_ADDR_ASYNC_CTL1)) ctl1_q <= pwdata;
         if (hit(paddr, CDG_ADDR_DOMAIN_DIS)) dis_q  <= pwdata;
         if (hit(paddr, CDG_ADDR_TIMER_SRC))  tsrc_q <= pwdata;
         if (hit(paddr, CDG_ADDR_CLOCK_TEST)) test_q <= pwdata;
      end
   end

   // Read mux, built in setup so the data is ready in the access phase
   always_comb begin
      prdata_d  = 32'h00000000;
      pslverr_d = 1'b0;
      if (hit(paddr, CDG_ADDR_ASYNC_CTL1)) prdata_d = ctl1_q;
      if (hit(paddr, CDG_ADDR_DOMAIN_DIS)) prdata_d = dis_q;
      if (hit(paddr, CDG_ADDR_TIMER_SRC))  prdata_d = tsrc_q;
      if (hit(paddr, CDG_ADDR_CLOCK_TEST)) prdata_d = test_q;
      if (hit(paddr, CDG_ADDR_STATUS)) begin
         prdata_d = {28'h0000000, timer_domain_en_q, async_clock4_en_q, divided_async3_en_q, async3_en_q};
      end
      if (!mapped(paddr)) begin
         pslverr_d = 1'b1;               // Unmapped reads zero and errors
      end
   end

   // ==========================================================================
   // APB response; fixed one-wait-free answer in the access phase
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & pslverr_d;
         if (rd_en) begin
            prdata <= prdata_d;
         end
      end
   end

   // ==========================================================================
   // Divided async 3 domain
   // ==========================================================================
   // Async 3 source runs unless its own disable bit is set
   assign a3_run = ~dis_q[CDG_DIS_A3_BIT];

   // Counter clears while stopped, so a restart gives a full first period
   cdg_divider u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (a3_run),                                      // Derived from async 3 source
      .ratio   (ctl1_q[CDG_RATIO_LSB +: CDG_RATIO_W]),        // Ratio 1..8
      .tick_q  (div_tick)
   );

   // Domain enables; gate bit only meaningful with source running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         async3_en_q         <= 1'b0;
         divided_async3_en_q <= 1'b0;
         async_clock4_en_q   <= 1'b0;
         timer_domain_en_q   <= 1'b0;
      end else begin
         async3_en_q         <= a3_run;
         divided_async3_en_q <= a3_run & div_tick & ~ctl1_q[CDG_A3_GATE_BIT];
         async_clock4_en_q   <= ~dis_q[CDG_DIS_A4_BIT]
                                & (ctl1_q[CDG_A4_SRC_LSB +: CDG_SRC_W] == CDG_SRC_PERIPH
                                   | alt_src_tick[ctl1_q[CDG_A4_SRC_LSB +: CDG_SRC_W]]);
         timer_domain_en_q   <= ~dis_q[CDG_DIS_TIMER_BIT] & tdiv_tick;
      end
   end

   // Timer source and prescale; software keeps the alt rate legal
   assign tdiv_tick = (tdiv_cnt_q == {1'b0, tsrc_q[CDG_TDIV_LSB +: CDG_TDIV_W]})
                      & (tsrc_q[CDG_TSRC_LSB +: CDG_SRC_W] == CDG_SRC_PERIPH
                         | alt_src_tick[tsrc_q[CDG_TSRC_LSB +: CDG_SRC_W]]);

   // Prescale counter; frozen while the picked source is quiet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdiv_cnt_q <= '0;
      end else if (tdiv_tick) begin
         tdiv_cnt_q <= '0;
      end else if (tsrc_q[CDG_TSRC_LSB +: CDG_SRC_W] == CDG_SRC_PERIPH
                   | alt_src_tick[tsrc_q[CDG_TSRC_LSB +: CDG_SRC_W]]) begin
         tdiv_cnt_q <= tdiv_cnt_q + 1'b1;
      end
   end

   // Visible square waves of the internal domains for the test pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tbase_q  <= 1'b0;
         a3_tog_q <= 1'b0;
         a4_tog_q <= 1'b0;
      end else begin
         if (timer_domain_en_q)   tbase_q  <= ~tbase_q;
         if (divided_async3_en_q) a3_tog_q <= ~a3_tog_q;
         if (async_clock4_en_q)   a4_tog_q <= ~a4_tog_q;
      end
   end

   // ==========================================================================
   // Clock test mux; unlisted slots are tied low
   // ==========================================================================
   always_comb begin
      ecp_src                = 16'h0000;                 // Reserved stay low
      ecp_src[CDG_ECP_OSC]   = osc_clk;
      ecp_src[CDG_ECP_PLL1]  = pll1_clk;
      ecp_src[CDG_ECP_EXT1]  = external_clock_input1;
      ecp_src[CDG_ECP_LF]    = low_freq_osc_clock;
      ecp_src[CDG_ECP_HF]    = high_freq_osc_clock;
      ecp_src[CDG_ECP_PLL2]  = pll2_clk;
      ecp_src[CDG_ECP_EXT2]  = external_clock_input2;
      ecp_src[CDG_ECP_CPU]   = cpu_clock;
      ecp_src[CDG_ECP_TBASE] = tbase_q;
      ecp_src[CDG_ECP_A1]    = async_clock1;
      ecp_src[CDG_ECP_A3]    = a3_tog_q;
      ecp_src[CDG_ECP_A4]    = a4_tog_q;
      gio_src                = 16'h0000;
      gio_src[CDG_GIO_OSCV]  = osc_valid;
      gio_src[CDG_GIO_PLL1V] = pll1_valid;
      gio_src[CDG_GIO_HFV]   = hf_valid;
      gio_src[CDG_GIO_PLL2V] = pll2_valid;
      gio_src[CDG_GIO_LF]    = low_freq_osc_clock;
   end

   // Registered pins: one cycle late, but no glitch on a selector change
   cdg_test_mux u_mux (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (test_q[CDG_TEST_EN_BIT]),
      .ecp_sel (test_q[CDG_ECP_LSB +: CDG_SEL_W]),
      .gio_sel (test_q[CDG_GIO_LSB +: CDG_SEL_W]),
      .ecp_src (ecp_src),
      .gio_src (gio_src),
      .ecp_q   (external_clock_out_pin),
      .gio_q   (timer_output_pin12)
   );

   // ==========================================================================
   // Assertions
   // ==========================================================================
   property p_reset_half;
      @(posedge pclk) $rose(presetn) |-> ctl1_q[CDG_RATIO_LSB +: CDG_RATIO_W] == 3'h1;
   endproperty
   a_reset_half: assert property (p_reset_half) else $error("reset ratio not divide by two");

   property p_gate;
      @(posedge pclk) disable iff (!presetn) ctl1_q[CDG_A3_GATE_BIT] |=> !divided_async3_en_q;
   endproperty
   a_gate: assert property (p_gate) else $error("divided clock runs while gated");

   property p_a3_off;
      @(posedge pclk) disable iff (!presetn) dis_q[CDG_DIS_A3_BIT] |=> !divided_async3_en_q && !async3_en_q;
   endproperty
   a_a3_off: assert property (p_a3_off) else $error("async 3 runs while disabled");

   property p_div_period;
      @(posedge pclk) disable iff (!presetn)
         div_tick && $stable(ctl1_q) && ctl1_q[CDG_RATIO_LSB +: CDG_RATIO_W] == 3'h1 && a3_run
         ##1 a3_run && ctl1_q[CDG_RATIO_LSB +: CDG_RATIO_W] == 3'h1 |=> div_tick;
   endproperty
   a_div_period: assert property (p_div_period) else $error("divide by two period wrong");

   property p_a4_off;
      @(posedge pclk) disable iff (!presetn) dis_q[CDG_DIS_A4_BIT] |=> !async_clock4_en_q;
   endproperty
   a_a4_off: assert property (p_a4_off) else $error("async 4 runs while disabled");

   property p_timer_off;
      @(posedge pclk) disable iff (!presetn) dis_q[CDG_DIS_TIMER_BIT] |=> !timer_domain_en_q;
   endproperty
   a_timer_off: assert property (p_timer_off) else $error("timer runs while disabled");

   property p_ecp_route;
      @(posedge pclk) disable iff (!presetn)
         test_q[CDG_TEST_EN_BIT] && test_q[CDG_ECP_LSB +: CDG_SEL_W] == CDG_ECP_CPU
         |=> external_clock_out_pin == $past(cpu_clock);
   endproperty
   a_ecp_route: assert property (p_ecp_route) else $error("cpu clock not on pin");

   property p_gio_route;
      @(posedge pclk) disable iff (!presetn)
         test_q[CDG_TEST_EN_BIT] && test_q[CDG_GIO_LSB +: CDG_SEL_W] == CDG_GIO_OSCV
         |=> timer_output_pin12 == $past(osc_valid);
   endproperty
   a_gio_route: assert property (p_gio_route) else $error("osc valid not on pin");

   property p_reserved;
      @(posedge pclk) disable iff (!presetn)
         test_q[CDG_ECP_LSB +: CDG_SEL_W] == 4'hF |=> !external_clock_out_pin;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code not low");

   // Enabled async 3 source shows its run flag next cycle
   property p_a3_run;
      @(posedge pclk) disable iff (!presetn) !dis_q[CDG_DIS_A3_BIT] |=> async3_en_q;
   endproperty
   a_a3_run: assert property (p_a3_run) else $error("async 3 stopped");

   property p_defaults;
      @(posedge pclk) $rose(presetn) |=> async_clock4_en_q && timer_domain_en_q;
   endproperty
   a_defaults: assert property (p_defaults) else $error("default domains idle");

   // First divided pulse two edges after release
   property p_div_first;
      @(posedge pclk) $rose(presetn) |-> ##1 !div_tick ##1 div_tick;
   endproperty
   a_div_first: assert property (p_div_first) else $error("first period not two");

   property p_pins_off;
      @(posedge pclk) disable iff (!presetn)
         !test_q[CDG_TEST_EN_BIT] |=> !external_clock_out_pin && !timer_output_pin12;
   endproperty
   a_pins_off: assert property (p_pins_off) else $error("pins driven outside test");

   property p_gio_reserved;
      @(posedge pclk) disable iff (!presetn)
         test_q[CDG_GIO_LSB +: CDG_SEL_W] == 4'hF |=> !timer_output_pin12;
   endproperty
   a_gio_reserved: assert property (p_gio_reserved) else $error("reserved timer code not low");

   // A picked source that does not tick keeps its domain idle
   property p_a4_alt;
      @(posedge pclk) disable iff (!presetn)
         ctl1_q[CDG_A4_SRC_LSB +: CDG_SRC_W] != CDG_SRC_PERIPH
         && !alt_src_tick[ctl1_q[CDG_A4_SRC_LSB +: CDG_SRC_W]] |=> !async_clock4_en_q;
   endproperty
   a_a4_alt: assert property (p_a4_alt) else $error("async 4 runs without source");

   property p_timer_alt;
      @(posedge pclk) disable iff (!presetn)
         tsrc_q[CDG_TSRC_LSB +: CDG_SRC_W] != CDG_SRC_PERIPH
         && !alt_src_tick[tsrc_q[CDG_TSRC_LSB +: CDG_SRC_W]] |=> !timer_domain_en_q;
   endproperty
   a_timer_alt: assert property (p_timer_alt) else $error("timer runs without source");

   // ==========================================================================
   // Cover points
   // ==========================================================================
   c_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en);
   c_div8: cover property (@(posedge pclk) disable iff (!presetn)
      div_tick && ctl1_q[CDG_RATIO_LSB +: CDG_RATIO_W] == 3'h7);
   c_test: cover property (@(posedge pclk) disable iff (!presetn) external_clock_out_pin);
   c_timer_alt: cover property (@(posedge pclk) disable iff (!presetn)
      timer_domain_en_q && tsrc_q[CDG_TSRC_LSB +: CDG_SRC_W] != CDG_SRC_PERIPH);
   c_gio: cover property (@(posedge pclk) disable iff (!presetn) timer_output_pin12);
endmodule

// ==== cdg_pkg.sv ====
package cdg_pkg;

   // ==========================================================================
   // Register map (byte addresses, APB word aligned)
   // ==========================================================================
   localparam logic [31:0] CDG_ADDR_ASYNC_CTL1  = 32'hFFFFE140;
   localparam logic [31:0] CDG_ADDR_DOMAIN_DIS  = 32'hFFFFE144;
   localparam logic [31:0] CDG_ADDR_TIMER_SRC   = 32'hFFFFE148;
   localparam logic [31:0] CDG_ADDR_CLOCK_TEST  = 32'hFFFFE14C;
   localparam logic [31:0] CDG_ADDR_STATUS      = 32'hFFFFE150;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int CDG_RATIO_LSB      = 0;    // async3_divide_ratio, ratio-1
   localparam int CDG_RATIO_W        = 3;
   localparam int CDG_A3_GATE_BIT    = 8;    // divided_async3_gate
   localparam int CDG_A4_SRC_LSB     = 16;   // async clock 4 source select
   localparam int CDG_SRC_W          = 4;
   localparam int CDG_DIS_A3_BIT     = 10;   // domain_disable_set bits
   localparam int CDG_DIS_TIMER_BIT  = 6;
   localparam int CDG_DIS_A4_BIT     = 11;
   localparam int CDG_TSRC_LSB       = 0;    // timer_source_select
   localparam int CDG_TDIV_LSB       = 8;    // timer_prescale_divider
   localparam int CDG_TDIV_W         = 2;
   localparam int CDG_ECP_LSB        = 0;    // ext_clock_pin_selector
   localparam int CDG_GIO_LSB        = 8;    // timer_pin_selector
   localparam int CDG_SEL_W          = 4;
   localparam int CDG_TEST_EN_BIT    = 24;   // clock test mode enable

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [31:0] CDG_RST_ASYNC_CTL1 = 32'h00000001; // ratio-1 = 1, /2
   localparam logic [31:0] CDG_RST_DOMAIN_DIS = 32'h00000000;
   localparam logic [31:0] CDG_RST_TIMER_SRC  = 32'h00000000;
   localparam logic [31:0] CDG_RST_CLOCK_TEST = 32'h00000000;
   localparam logic [3:0]  CDG_SRC_PERIPH     = 4'h0;         // peripheral clock

   // ==========================================================================
   // Test mux codes
   // ==========================================================================
   localparam logic [3:0] CDG_ECP_OSC   = 4'h0;
   localparam logic [3:0] CDG_ECP_PLL1  = 4'h1;
   localparam logic [3:0] CDG_ECP_EXT1  = 4'h3;
   localparam logic [3:0] CDG_ECP_LF    = 4'h4;
   localparam logic [3:0] CDG_ECP_HF    = 4'h5;
   localparam logic [3:0] CDG_ECP_PLL2  = 4'h6;
   localparam logic [3:0] CDG_ECP_EXT2  = 4'h7;
   localparam logic [3:0] CDG_ECP_CPU   = 4'h8;
   localparam logic [3:0] CDG_ECP_TBASE = 4'h9;
   localparam logic [3:0] CDG_ECP_A1    = 4'hB;
   localparam logic [3:0] CDG_ECP_A3    = 4'hD;
   localparam logic [3:0] CDG_ECP_A4    = 4'hE;
   localparam logic [3:0] CDG_GIO_OSCV  = 4'h0;
   localparam logic [3:0] CDG_GIO_PLL1V = 4'h1;
   localparam logic [3:0] CDG_GIO_HFV   = 4'h5;
   localparam logic [3:0] CDG_GIO_PLL2V = 4'h6;
   localparam logic [3:0] CDG_GIO_LF    = 4'h8;

   // Divider state
   typedef enum logic [0:0] {
      CDG_DIV_LOW  = 1'b0,
      CDG_DIV_HIGH = 1'b1
   } cdg_div_state_t;

endpackage

// ==== cdg_divider.sv ====
`timescale 1ns/1ps
// Divide-by-N enable generator, N = ratio + 1 (1..8); one pulse every N clocks
module cdg_divider
   import cdg_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   run,
   input  wire logic [CDG_RATIO_W-1:0] ratio,
   output logic                        tick_q
);
   logic [CDG_RATIO_W-1:0] cnt_q;

   // ==========================================================================
   // Counter; a ratio change takes effect at once, a count at or past the new ratio wraps on the next edge
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (!run) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (cnt_q >= ratio) begin
         cnt_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end
endmodule

// ==== cdg_test_mux.sv ====
`timescale 1ns/1ps
// Registered test-pin selectors; reserved codes give a constant low
module cdg_test_mux
   import cdg_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 enable,
   input  wire logic [CDG_SEL_W-1:0] ecp_sel,
   input  wire logic [CDG_SEL_W-1:0] gio_sel,
   input  wire logic [15:0]          ecp_src,
   input  wire logic [15:0]          gio_src,
   output logic                      ecp_q,
   output logic                      gio_q
);
   // ==========================================================================
   // Pin registers, low outside test mode
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ecp_q <= 1'b0;
         gio_q <= 1'b0;
      end else begin
         ecp_q <= enable & ecp_src[ecp_sel];
         gio_q <= enable & gio_src[gio_sel];
      end
   end
endmodule

// ==== clock_domain_gating_and_test_mux_tb.sv ====
`timescale 1ns/1ps
module clock_domain_gating_and_test_mux_tb;
   import cdg_pkg::*;

   // ==========================================================================
   // Signals
   // ==========================================================================
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [12:0] s;
   logic [15:0] alt;
   logic        a3_en;
   logic        d3_en;
   logic        a4_en;
   logic        tm_en;
   logic        ecp_pin;
   logic        gio_pin;
   int          bad_count;
   int          tests_run;

   cdg_clock_domains uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_clk(s[0]), .pll1_clk(s[1]), .external_clock_input1(s[2]), .low_freq_osc_clock(s[3]),
      .high_freq_osc_clock(s[4]), .pll2_clk(s[5]), .external_clock_input2(s[6]), .cpu_clock(s[7]),
      .async_clock1(s[8]), .osc_valid(s[9]), .pll1_valid(s[10]), .hf_valid(s[11]), .pll2_valid(s[12]),
      .alt_src_tick(alt), .async3_en_q(a3_en), .divided_async3_en_q(d3_en), .async_clock4_en_q(a4_en),
      .timer_domain_en_q(tm_en), .external_clock_out_pin(ecp_pin), .timer_output_pin12(gio_pin));

   // ==========================================================================
   // Clock, 40 MHz
   // ==========================================================================
   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;

   // ==========================================================================
   // Checking and closing
   // ==========================================================================
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask

   task automatic results();
      $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================================================
   // APB master: setup, then access until pready seen at a rising edge
   // ==========================================================================
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ready, data and error are all taken at one rising edge
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            $display("[FAIL] apb_timeout expected 1 seen 0");
            bad_count++;
            results();
         end
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h00000000, r, e);
      check(name, r, exp);
      check("pslverr", {31'h0, e}, {31'h0, exp_err});
   endtask

   // Counts cycles in which the chosen enable is high, seen mid-cycle
   task automatic cnt(input int which, input int cyc, output int c);
      c = 0;
      repeat (cyc) begin
         @(negedge pclk);
         case (which)
            0: c += (a3_en === 1'b1);
            1: c += (d3_en === 1'b1);
            2: c += (a4_en === 1'b1);
            default: c += (tm_en === 1'b1);
         endcase
      end
   endtask

   // Source index per selector code: -1 reserved, -2 internal domain
   function automatic int map(input logic gio, input logic [3:0] c);
      if (gio) begin
         case (c)
            4'h0: return 9;
            4'h1: return 10;
            4'h5: return 11;
            4'h6: return 12;
            4'h8: return 3;
            default: return -1;
         endcase
      end
      case (c)
         4'h0: return 0;
         4'h1: return 1;
         4'h3: return 2;
         4'h4: return 3;
         4'h5: return 4;
         4'h6: return 5;
         4'h7: return 6;
         4'h8: return 7;
         4'hB: return 8;
         4'h9, 4'hD, 4'hE: return -2;
         default: return -1;
      endcase
   endfunction

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      int c;
      int idx;
      logic [3:0] code;
      logic g;
      bad_count = 0;
      tests_run = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      s = 13'h0000;
      alt = 16'h0000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctl1_reset", CDG_ADDR_ASYNC_CTL1, 32'h00000001, 1'b0);
      rd("disable_reset", CDG_ADDR_DOMAIN_DIS, 32'h00000000, 1'b0);
      rd("timer_src_reset", CDG_ADDR_TIMER_SRC, 32'h00000000, 1'b0);
      rd("clock_test_reset", CDG_ADDR_CLOCK_TEST, 32'h00000000, 1'b0);
      rd("unmapped", 32'hFFFFE160, 32'h00000000, 1'b1);
      cnt(1, 16, c);
      check("div_default", c, 8);
      // Every ratio; a window of eight periods holds exactly eight pulses
      for (int r = 0; r < 8; r++) begin
         wr(CDG_ADDR_ASYNC_CTL1, r);
         rd("ctl1_ratio", CDG_ADDR_ASYNC_CTL1, r, 1'b0);
         repeat (10) @(posedge pclk);
         cnt(1, 8 * (r + 1), c);
         check("div_pulses", c, 8);
      end
      wr(CDG_ADDR_ASYNC_CTL1, 32'h00000101);
      repeat (4) @(posedge pclk);
      cnt(1, 16, c);
      check("div_gated", c, 0);
      cnt(0, 8, c);
      check("a3_runs_gated", c, 8);
      rd("status_gated", CDG_ADDR_STATUS, 32'h0000000D, 1'b0);
      wr(CDG_ADDR_ASYNC_CTL1, 32'h00000001);
      wr(CDG_ADDR_DOMAIN_DIS, 32'h00000400);
      repeat (4) @(posedge pclk);
      cnt(0, 8, c);
      check("a3_disabled", c, 0);
      cnt(1, 16, c);
      check("div_src_off", c, 0);
      wr(CDG_ADDR_DOMAIN_DIS, 32'h00000000);
      repeat (4) @(posedge pclk);
      cnt(2, 16, c);
      check("a4_default", c, 16);
      cnt(3, 16, c);
      check("timer_default", c, 16);
      wr(CDG_ADDR_DOMAIN_DIS, 32'h00000840);
      repeat (4) @(posedge pclk);
      cnt(2, 16, c);
      check("a4_disabled", c, 0);
      cnt(3, 16, c);
      check("timer_disabled", c, 0);
      wr(CDG_ADDR_DOMAIN_DIS, 32'h00000000);
      // Alternate sources idle, then tick every cycle; prescale by three keeps a third
      wr(CDG_ADDR_TIMER_SRC, 32'h00000202);
      wr(CDG_ADDR_ASYNC_CTL1, 32'h00020001);
      repeat (4) @(posedge pclk);
      cnt(3, 16, c);
      check("timer_alt_idle", c, 0);
      cnt(2, 16, c);
      check("a4_alt_idle", c, 0);
      @(posedge pclk);
      alt <= 16'hFFFF;
      repeat (4) @(posedge pclk);
      cnt(3, 15, c);
      check("timer_alt_div", c, 5);
      cnt(2, 16, c);
      check("a4_alt_run", c, 16);
      wr(CDG_ADDR_TIMER_SRC, 32'h00000000);
      // Test mux: one-hot source for external codes, all high for reserved ones, all low for internal ones
      for (int k = 0; k < 32; k++) begin
         g = k[4];
         code = k[3:0];
         idx = map(g, code);
         @(posedge pclk);
         s <= (idx >= 0) ? (13'h0001 << idx) : ((idx == -1) ? 13'h1FFF : 13'h0000);
         wr(CDG_ADDR_CLOCK_TEST, g ? (32'h01000000 | {code, 8'h00}) : (32'h01000000 | code));
         repeat (4) @(posedge pclk);
         if (idx == -2) begin
            // Internal domains toggle: half of eight samples are high
            c = 0;
            repeat (8) begin
               @(negedge pclk);
               c += (ecp_pin === 1'b1);
            end
            check("ext_pin_toggle", c, 4);
         end else begin
            check(g ? "timer_pin" : "ext_pin", g ? gio_pin : ecp_pin, idx != -1);
         end
      end
      s <= 13'h1FFF;
      wr(CDG_ADDR_CLOCK_TEST, 32'h00000000);
      repeat (4) @(posedge pclk);
      check("pins_off", {30'h0, ecp_pin, gio_pin}, 32'h00000000);
      results();
   end
endmodule
